/* cssr_defs.svh */
// constants for the core special status register block
// assumes inclusion by bare name from package and design files
`ifndef CSSR_DEFS_SVH
`define CSSR_DEFS_SVH

// special register selects seen on the move instructions
`define CSSR_SEL_STATUS 2'h0
`define CSSR_SEL_MASK 2'h1
`define CSSR_SEL_CONTROL 2'h2

// field positions
`define CSSR_T_BIT 24
`define CSSR_MASK_BIT 0
`define CSSR_SPSEL_BIT 1
`define CSSR_VEC_T_BIT 0

// reset values
`define CSSR_MASK_RST 1'b0
`define CSSR_SPSEL_RST 1'b0
`define CSSR_T_RST 1'b0

// access sizes
`define CSSR_SIZE_BYTE 2'h0
`define CSSR_SIZE_HALF 2'h1
`define CSSR_SIZE_WORD 2'h2

// fixed memory map, then multi-transfer index width
`define CSSR_PRIV_BASE 32'hE000_0000
`define CSSR_PRIV_END 32'hE00F_FFFF
`define CSSR_CORE_PERIPH_BASE 32'hE000_E000
`define CSSR_CORE_PERIPH_END 32'hE000_EFFF
`define CSSR_XFER_IDX_W 4
`endif

/* cssr_pkg.sv */
// types for the core special status register block
// assumes cssr_defs.svh is on the include path
package cssr_pkg;
    `include "cssr_defs.svh"

    typedef enum logic [1:0] {
        MULTI_IDLE,
        MULTI_RUN,
        MULTI_ABANDONED
    } cssr_multi_t;

    typedef enum logic [2:0] {
        REG_CODE,
        REG_SRAM,
        REG_PERIPH,
        REG_EXT_RAM,
        REG_EXT_DEVICE,
        REG_PRIV,
        REG_VENDOR
    } cssr_region_t;
endpackage

/* cssr_core_special_status_regs.sv */
// special status state of the core: state flag, priority mask, stack select,
// mode, restartable multi-transfer tracking and little-endian access steering
// assumes the pipeline drives all inputs synchronously to CLK, one-cycle event strobes
// Contract
// - state flag at bit 24, reads zero
// - writes to status word discarded
// - exchange branches load flag from target bit0
// - exception return restores flag from stack
// - exception entry loads flag from vector bit0
// - flag zero on issue faults or locks
// - interrupt abandons multi-register transfer
// - abandoned transfer restarts from first beat
// - priority mask bit0 blocks configurable exceptions
// - mask written by move or change-state
// - thread mode stack chosen by bit1
// - handler mode stack bit reads zero, ignores writes
// - handler mode always uses main stack
// - entry and return update stack control
// - reset selects main stack in thread
// - non-reset exceptions run in handler mode
// - word, halfword, byte accesses little-endian
// - fetches and peripheral bus little-endian
// - fixed non-reconfigurable 4GB map decode
// - reset loads flag from reset vector bit0
`timescale 1ns/1ps
`include "cssr_defs.svh"

module cssr_core_special_status_regs (
    input wire logic CLK,
    input wire logic RST,
    input wire logic RESET_VEC_LOAD,
    input wire logic [31:0] RESET_VEC,
    input wire logic SREG_RD_EN,
    input wire logic SREG_WR_EN,
    input wire logic [1:0] SREG_SEL,
    input wire logic [31:0] SREG_WR_DATA,
    input wire logic CHG_STATE_EN,
    input wire logic CHG_STATE_DISABLE,
    input wire logic BRANCH_XCHG,
    input wire logic [31:0] BRANCH_TARGET,
    input wire logic EXC_ENTRY,
    input wire logic [31:0] EXC_VECTOR,
    input wire logic EXC_RETURN,
    input wire logic [31:0] STACKED_STATUS,
    input wire logic RETURN_TO_THREAD,
    input wire logic RETURN_PROC_STACK,
    input wire logic INSTR_ISSUE,
    input wire logic IN_HARD_FAULT,
    input wire logic CFG_EXC_REQ,
    input wire logic MULTI_START,
    input wire logic MULTI_BEAT,
    input wire logic MULTI_LAST,
    input wire logic IRQ_PENDING,
    input wire logic ACC_VALID,
    input wire logic [31:0] ACC_ADDR,
    input wire logic [1:0] ACC_SIZE,
    input wire logic [31:0] ACC_WDATA,
    input wire logic [31:0] ACC_RDATA_BUS,
    output logic [31:0] SREG_RD_DATA,
    output logic SREG_RD_VALID,
    output logic T_FLAG,
    output logic PRIO_MASK,
    output logic USE_PROC_STACK,
    output logic HANDLER_MODE,
    output logic EXEC_ALLOW,
    output logic HARD_FAULT_REQ,
    output logic LOCKUP,
    output logic CFG_EXC_ALLOW,
    output logic MULTI_ABANDON,
    output logic MULTI_RESTART,
    output logic [`CSSR_XFER_IDX_W-1:0] MULTI_IDX,
    output logic [3:0] ACC_BYTE_EN,
    output logic [31:0] ACC_WDATA_LANE,
    output logic [31:0] ACC_RDATA,
    output cssr_pkg::cssr_region_t ACC_REGION,
    output logic ACC_XN,
    output logic ACC_CORE_PERIPH,
    output logic ACC_ERR
);
    import cssr_pkg::*;

    typedef struct packed {
        logic t_flag;
        logic prio_mask;
        logic spsel;
        logic handler;
        logic lockup;
        logic fault;
        logic [31:0] rd_data;
        logic rd_valid;
        cssr_multi_t multi;
        logic [`CSSR_XFER_IDX_W-1:0] idx;
        logic abandon;
        logic restart;
        logic [3:0] byte_en;
        logic [31:0] wlane;
        logic [31:0] rdata;
        cssr_region_t region;
        logic xn;
        logic core_periph;
        logic err;
    } cssr_state_t;

    cssr_state_t st;
    cssr_state_t next_st;
    logic [1:0] lane;
    logic misaligned;
    logic [31:0] shifted_rd;

    assign EXEC_ALLOW = INSTR_ISSUE && st.t_flag && !st.lockup;
    assign CFG_EXC_ALLOW = CFG_EXC_REQ && !st.prio_mask;
    assign USE_PROC_STACK = st.spsel && !st.handler;

    always_comb begin
        next_st = st;
        next_st.rd_valid = 1'b0;
        next_st.fault = 1'b0;
        next_st.abandon = 1'b0;
        next_st.restart = 1'b0;
        lane = ACC_ADDR[1:0];
        misaligned = 1'b0;
        shifted_rd = 32'h0000_0000;

        // state flag sources, reset vector over entry over return over branch
        if (RESET_VEC_LOAD) begin
            next_st.t_flag = RESET_VEC[`CSSR_VEC_T_BIT];
        end else if (EXC_ENTRY) begin
            next_st.t_flag = EXC_VECTOR[`CSSR_VEC_T_BIT];
        end else if (EXC_RETURN) begin
            next_st.t_flag = STACKED_STATUS[`CSSR_T_BIT];
        end else if (BRANCH_XCHG) begin
            next_st.t_flag = BRANCH_TARGET[0];
        end

        // mode and stack control
        if (EXC_ENTRY) begin
            next_st.handler = 1'b1;
            next_st.spsel = 1'b0;
        end else if (EXC_RETURN) begin
            next_st.handler = !RETURN_TO_THREAD;
            next_st.spsel = RETURN_TO_THREAD && RETURN_PROC_STACK;
        end else if (SREG_WR_EN && SREG_SEL == `CSSR_SEL_CONTROL && !st.handler) begin
            next_st.spsel = SREG_WR_DATA[`CSSR_SPSEL_BIT];
        end

        // priority mask; status word writes fall through unhandled
        if (SREG_WR_EN && SREG_SEL == `CSSR_SEL_MASK) begin
            next_st.prio_mask = SREG_WR_DATA[`CSSR_MASK_BIT];
        end else if (CHG_STATE_EN) begin
            next_st.prio_mask = CHG_STATE_DISABLE;
        end

        // special register read
        if (SREG_RD_EN) begin
            next_st.rd_valid = 1'b1;
            case (SREG_SEL)
                `CSSR_SEL_STATUS: next_st.rd_data = 32'h0000_0000;
                `CSSR_SEL_MASK: next_st.rd_data = {31'h0000_0000, st.prio_mask};
                `CSSR_SEL_CONTROL: next_st.rd_data = {30'h0000_0000, st.spsel && !st.handler, 1'b0};
                default: next_st.rd_data = 32'h0000_0000;
            endcase
        end

        // issue with cleared flag: fault, or lockup when already in hard fault
        if (INSTR_ISSUE && !st.t_flag && !st.lockup) begin
            if (IN_HARD_FAULT) begin
                next_st.lockup = 1'b1;
            end else begin
                next_st.fault = 1'b1;
            end
        end

        // restartable multi-register transfer
        case (st.multi)
            MULTI_IDLE: begin
                if (MULTI_START) begin
                    next_st.multi = MULTI_RUN;
                    next_st.idx = '0;
                end
            end
            MULTI_RUN: begin
                if (IRQ_PENDING) begin
                    next_st.multi = MULTI_ABANDONED;
                    next_st.abandon = 1'b1;
                    next_st.idx = '0;
                end else if (MULTI_BEAT && MULTI_LAST) begin
                    next_st.multi = MULTI_IDLE;
                end else if (MULTI_BEAT) begin
                    next_st.idx = st.idx + 1'b1;
                end
            end
            MULTI_ABANDONED: begin
                if (EXC_RETURN) begin
                    next_st.multi = MULTI_IDLE;
                    next_st.restart = 1'b1;
                    next_st.idx = '0;
                end
            end
            default: next_st.multi = MULTI_IDLE;
        endcase

        // little-endian lane steering and fixed map decode
        if (ACC_VALID) begin
            case (ACC_SIZE)
                `CSSR_SIZE_BYTE: begin
                    next_st.byte_en = 4'h1 << lane;
                    next_st.wlane = {4{ACC_WDATA[7:0]}};
                    shifted_rd = ACC_RDATA_BUS >> {lane, 3'h0};
                    next_st.rdata = {24'h00_0000, shifted_rd[7:0]};
                end
                `CSSR_SIZE_HALF: begin
                    misaligned = lane[0];
                    next_st.byte_en = lane[1] ? 4'hC : 4'h3;
                    next_st.wlane = {2{ACC_WDATA[15:0]}};
                    shifted_rd = lane[1] ? {16'h0000, ACC_RDATA_BUS[31:16]} : ACC_RDATA_BUS;
                    next_st.rdata = {16'h0000, shifted_rd[15:0]};
                end
                `CSSR_SIZE_WORD: begin
                    misaligned = lane != 2'h0;
                    next_st.byte_en = 4'hF;
                    next_st.wlane = ACC_WDATA;
                    next_st.rdata = ACC_RDATA_BUS;
                end
                default: begin
                    misaligned = 1'b1;
                    next_st.byte_en = 4'h0;
                    next_st.wlane = 32'h0000_0000;
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
            case (ACC_ADDR[31:29])
                3'h0: next_st.region = REG_CODE;
                3'h1: next_st.region = REG_SRAM;
                3'h2: next_st.region = REG_PERIPH;
                3'h3, 3'h4: next_st.region = REG_EXT_RAM;
                3'h5, 3'h6: next_st.region = REG_EXT_DEVICE;
                default: next_st.region = (ACC_ADDR <= `CSSR_PRIV_END) ? REG_PRIV : REG_VENDOR;
            endcase
            next_st.xn = !(next_st.region == REG_CODE || next_st.region == REG_SRAM
                || next_st.region == REG_EXT_RAM);
            next_st.core_periph = ACC_ADDR >= `CSSR_CORE_PERIPH_BASE
                && ACC_ADDR <= `CSSR_CORE_PERIPH_END;
            next_st.err = misaligned
                || (next_st.region == REG_PRIV && ACC_SIZE != `CSSR_SIZE_WORD);
        end else begin
            next_st.byte_en = 4'h0;
            next_st.err = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
            st.t_flag <= `CSSR_T_RST;
            st.prio_mask <= `CSSR_MASK_RST;
            st.spsel <= `CSSR_SPSEL_RST;
            st.multi <= MULTI_IDLE;
            st.region <= REG_CODE;
        end else begin
            st <= next_st;
        end
    end

    assign SREG_RD_DATA = st.rd_data;
    assign SREG_RD_VALID = st.rd_valid;
    assign T_FLAG = st.t_flag;
    assign PRIO_MASK = st.prio_mask;
    assign HANDLER_MODE = st.handler;
    assign HARD_FAULT_REQ = st.fault;
    assign LOCKUP = st.lockup;
    assign MULTI_ABANDON = st.abandon;
    assign MULTI_RESTART = st.restart;
    assign MULTI_IDX = st.idx;
    assign ACC_BYTE_EN = st.byte_en;
    assign ACC_WDATA_LANE = st.wlane;
    assign ACC_RDATA = st.rdata;
    assign ACC_REGION = st.region;
    assign ACC_XN = st.xn;
    assign ACC_CORE_PERIPH = st.core_periph;
    assign ACC_ERR = st.err;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    AST_STATUS_READ_ZERO: assert property (
        SREG_RD_EN && SREG_SEL == `CSSR_SEL_STATUS |=> SREG_RD_VALID && SREG_RD_DATA == 32'h0000_0000)
        else $error("status word read not zero");
    AST_STATUS_WRITE_IGNORED: assert property (
        SREG_WR_EN && SREG_SEL == `CSSR_SEL_STATUS && !RESET_VEC_LOAD && !EXC_ENTRY && !EXC_RETURN
        && !BRANCH_XCHG |=> $stable(T_FLAG))
        else $error("status word write changed flag");
    AST_BRANCH_FLAG: assert property (
        BRANCH_XCHG && !RESET_VEC_LOAD && !EXC_ENTRY && !EXC_RETURN |=> T_FLAG == $past(BRANCH_TARGET[0]))
        else $error("branch did not load flag");
    AST_ENTRY_FLAG: assert property (
        EXC_ENTRY && !RESET_VEC_LOAD |=> T_FLAG == $past(EXC_VECTOR[0]) && HANDLER_MODE && !USE_PROC_STACK)
        else $error("entry did not load flag or mode");
    AST_FAULT_ON_CLEAR: assert property (
        INSTR_ISSUE && !T_FLAG && !LOCKUP |-> !EXEC_ALLOW ##1 (HARD_FAULT_REQ || LOCKUP))
        else $error("cleared flag did not fault");
    AST_ABANDON: assert property (
        st.multi == MULTI_RUN && IRQ_PENDING |=> MULTI_ABANDON && MULTI_IDX == '0)
        else $error("transfer not abandoned");
    AST_RESTART_FIRST: assert property (
        MULTI_ABANDON ##[0:8] MULTI_RESTART |-> MULTI_IDX == '0)
        else $error("restart not from first beat");
    AST_MASK_BLOCKS: assert property (
        PRIO_MASK && CFG_EXC_REQ |-> !CFG_EXC_ALLOW)
        else $error("mask did not block");
    AST_CHG_STATE_SETS: assert property (
        CHG_STATE_EN && !SREG_WR_EN |=> PRIO_MASK == $past(CHG_STATE_DISABLE))
        else $error("change-state did not update mask");
    AST_HANDLER_MAIN_STACK: assert property (
        HANDLER_MODE |-> !USE_PROC_STACK)
        else $error("handler on process stack");
    AST_HANDLER_WRITE_IGNORED: assert property (
        HANDLER_MODE && SREG_WR_EN && SREG_SEL == `CSSR_SEL_CONTROL && !EXC_ENTRY && !EXC_RETURN
        |=> $stable(st.spsel))
        else $error("handler write changed stack select");
    AST_WORD_LANES: assert property (
        ACC_VALID && ACC_SIZE == `CSSR_SIZE_WORD |=> ACC_BYTE_EN == 4'hF && ACC_WDATA_LANE == $past(ACC_WDATA))
        else $error("word lanes wrong");
endmodule

/* core_special_status_regs_test.sv */
// self-checking bench for the core special status register block
// assumes cssr_pkg and cssr_core_special_status_regs are compiled first
`timescale 1ns/1ps
`include "cssr_defs.svh"

module core_special_status_regs_test;
    import cssr_pkg::*;
    logic clk, rst, reset_vec_load, sreg_rd_en, sreg_wr_en, chg_state_en, chg_state_disable, branch_xchg, exc_entry;
    logic exc_return, return_to_thread, return_proc_stack, instr_issue, in_hard_fault, cfg_exc_req;
    logic multi_start, multi_beat, multi_last, irq_pending, acc_valid;
    logic [1:0] sreg_sel, acc_size;
    logic [31:0] reset_vec, sreg_wr_data, branch_target, exc_vector, stacked_status, acc_addr, acc_wdata;
    logic [31:0] acc_rdata_bus, sreg_rd_data, acc_wdata_lane, acc_rdata;
    logic sreg_rd_valid, t_flag, prio_mask, use_proc_stack, handler_mode, exec_allow, hard_fault_req, lockup;
    logic cfg_exc_allow, multi_abandon, multi_restart, acc_xn, acc_core_periph, acc_err;
    logic [`CSSR_XFER_IDX_W-1:0] multi_idx;
    logic [3:0] acc_byte_en;
    logic [2:0] acc_region;
    int mismatches = 0;
    int n_checks = 0;

    cssr_core_special_status_regs dut (
        .CLK(clk), .RST(rst), .RESET_VEC_LOAD(reset_vec_load), .RESET_VEC(reset_vec),
        .SREG_RD_EN(sreg_rd_en), .SREG_WR_EN(sreg_wr_en), .SREG_SEL(sreg_sel), .SREG_WR_DATA(sreg_wr_data),
        .CHG_STATE_EN(chg_state_en), .CHG_STATE_DISABLE(chg_state_disable),
        .BRANCH_XCHG(branch_xchg), .BRANCH_TARGET(branch_target),
        .EXC_ENTRY(exc_entry), .EXC_VECTOR(exc_vector), .EXC_RETURN(exc_return),
        .STACKED_STATUS(stacked_status), .RETURN_TO_THREAD(return_to_thread),
        .RETURN_PROC_STACK(return_proc_stack),
        .INSTR_ISSUE(instr_issue), .IN_HARD_FAULT(in_hard_fault), .CFG_EXC_REQ(cfg_exc_req),
        .MULTI_START(multi_start), .MULTI_BEAT(multi_beat), .MULTI_LAST(multi_last), .IRQ_PENDING(irq_pending),
        .ACC_VALID(acc_valid), .ACC_ADDR(acc_addr), .ACC_SIZE(acc_size), .ACC_WDATA(acc_wdata),
        .ACC_RDATA_BUS(acc_rdata_bus), .SREG_RD_DATA(sreg_rd_data), .SREG_RD_VALID(sreg_rd_valid),
        .T_FLAG(t_flag), .PRIO_MASK(prio_mask), .USE_PROC_STACK(use_proc_stack), .HANDLER_MODE(handler_mode),
        .EXEC_ALLOW(exec_allow), .HARD_FAULT_REQ(hard_fault_req), .LOCKUP(lockup), .CFG_EXC_ALLOW(cfg_exc_allow),
        .MULTI_ABANDON(multi_abandon), .MULTI_RESTART(multi_restart), .MULTI_IDX(multi_idx),
        .ACC_BYTE_EN(acc_byte_en), .ACC_WDATA_LANE(acc_wdata_lane), .ACC_RDATA(acc_rdata),
        .ACC_REGION(acc_region), .ACC_XN(acc_xn), .ACC_CORE_PERIPH(acc_core_periph), .ACC_ERR(acc_err)
    );

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic vec_bit);
        @(posedge clk) rst <= 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        reset_vec_load <= 1'h1;
        reset_vec <= {31'h0000_0000, vec_bit};
        @(posedge clk) reset_vec_load <= 1'h0;
        #1;
    endtask

    task automatic sreg_write(input logic [1:0] sel, input logic [31:0] data);
        @(posedge clk) sreg_wr_en <= 1'h1;
        sreg_sel <= sel;
        sreg_wr_data <= data;
        @(posedge clk) sreg_wr_en <= 1'h0;
        #1;
    endtask

    task automatic sreg_read(input logic [1:0] sel, input logic [31:0] exp, input string what);
        @(posedge clk) sreg_rd_en <= 1'h1;
        sreg_sel <= sel;
        @(posedge clk) sreg_rd_en <= 1'h0;
        #1;
        check("read valid", sreg_rd_valid, 32'h0000_0001);
        check(what, sreg_rd_data, exp);
    endtask

    task automatic test_reset_and_status;
        check("t flag after reset", t_flag, 32'h0000_0001);
        check("process stack after reset", use_proc_stack, 32'h0000_0000);
        check("handler after reset", handler_mode, 32'h0000_0000);
        check("mask after reset", prio_mask, 32'h0000_0000);
        sreg_write(`CSSR_SEL_STATUS, 32'hFFFF_FFFF);
        check("t flag after status write", t_flag, 32'h0000_0001);
        sreg_read(`CSSR_SEL_STATUS, 32'h0000_0000, "status read");
        sreg_read(2'h3, 32'h0000_0000, "unused select read");
        $display("test reset_and_status done");
    endtask

    task automatic test_mask;
        cfg_exc_req <= 1'h1;
        sreg_write(`CSSR_SEL_MASK, 32'hFFFF_FFFF);
        check("allow with mask set", cfg_exc_allow, 32'h0000_0000);
        sreg_read(`CSSR_SEL_MASK, 32'h0000_0001, "mask read");
        @(posedge clk) chg_state_en <= 1'h1;
        chg_state_disable <= 1'h0;
        @(posedge clk) chg_state_disable <= 1'h1;
        #1;
        check("mask after change state", prio_mask, 32'h0000_0000);
        check("allow with mask clear", cfg_exc_allow, 32'h0000_0001);
        @(posedge clk) chg_state_en <= 1'h0;
        #1;
        check("mask set by change state", prio_mask, 32'h0000_0001);
        $display("test mask done");
    endtask

    task automatic test_stack_and_fault;
        sreg_write(`CSSR_SEL_CONTROL, 32'hFFFF_FFFF);
        check("process stack in thread", use_proc_stack, 32'h0000_0001);
        sreg_read(`CSSR_SEL_CONTROL, 32'h0000_0002, "control read thread");
        @(posedge clk) exc_entry <= 1'h1;
        exc_vector <= 32'h0000_0100;
        @(posedge clk) exc_entry <= 1'h0;
        #1;
        check("handler on entry", handler_mode, 32'h0000_0001);
        check("t flag from vector", t_flag, 32'h0000_0000);
        check("process stack in handler", use_proc_stack, 32'h0000_0000);
        sreg_write(`CSSR_SEL_CONTROL, 32'h0000_0002);
        sreg_read(`CSSR_SEL_CONTROL, 32'h0000_0000, "control read handler");
        check("process stack after handler write", use_proc_stack, 32'h0000_0000);
        @(posedge clk) instr_issue <= 1'h1;
        #1;
        check("exec allow with flag clear", exec_allow, 32'h0000_0000);
        @(posedge clk) instr_issue <= 1'h0;
        #1;
        check("hard fault request", hard_fault_req, 32'h0000_0001);
        @(posedge clk) instr_issue <= 1'h1;
        in_hard_fault <= 1'h1;
        @(posedge clk) instr_issue <= 1'h0;
        in_hard_fault <= 1'h0;
        @(posedge clk) #1;
        check("lockup sticky", lockup, 32'h0000_0001);
        $display("test stack_and_fault done");
    endtask

    task automatic test_return_branch;
        @(posedge clk) exc_entry <= 1'h1;
        exc_vector <= 32'h0000_0101;
        @(posedge clk) exc_entry <= 1'h0;
        exc_return <= 1'h1;
        stacked_status <= 32'h0100_0000;
        return_to_thread <= 1'h1;
        return_proc_stack <= 1'h1;
        @(posedge clk) exc_return <= 1'h0;
        #1;
        check("t flag from stack", t_flag, 32'h0000_0001);
        check("thread after return", handler_mode, 32'h0000_0000);
        check("process stack after return", use_proc_stack, 32'h0000_0001);
        @(posedge clk) branch_xchg <= 1'h1;
        branch_target <= 32'h0000_2000;
        @(posedge clk) branch_target <= 32'h0000_2001;
        #1;
        check("t flag branch clear", t_flag, 32'h0000_0000);
        @(posedge clk) branch_xchg <= 1'h0;
        #1;
        check("t flag branch set", t_flag, 32'h0000_0001);
        @(posedge clk) instr_issue <= 1'h1;
        #1;
        check("exec allow with flag set", exec_allow, 32'h0000_0001);
        @(posedge clk) exc_return <= 1'h1;
        instr_issue <= 1'h0;
        stacked_status <= 32'hFEFF_FFFF;
        @(posedge clk) exc_return <= 1'h0;
        #1;
        check("t flag cleared by stack", t_flag, 32'h0000_0000);
        $display("test return_branch done");
    endtask

    task automatic test_multi;
        @(posedge clk) multi_start <= 1'h1;
        @(posedge clk) multi_start <= 1'h0;
        multi_beat <= 1'h1;
        @(posedge clk) multi_beat <= 1'h0;
        irq_pending <= 1'h1;
        #1;
        check("beat index", multi_idx, 32'h0000_0001);
        @(posedge clk) irq_pending <= 1'h0;
        #1;
        check("abandon pulse", multi_abandon, 32'h0000_0001);
        check("index cleared", multi_idx, 32'h0000_0000);
        @(posedge clk) exc_return <= 1'h1;
        @(posedge clk) exc_return <= 1'h0;
        #1;
        check("restart pulse", multi_restart, 32'h0000_0001);
        $display("test multi done");
    endtask

    task automatic acc(input logic [31:0] addr, input logic [1:0] size, input logic [31:0] wd, input logic [3:0] en,
                       input logic [31:0] lane, input logic [31:0] rd, input logic [2:0] reg_code,
                       input logic xn, input logic cp, input logic err);
        @(posedge clk) acc_valid <= 1'h1;
        acc_addr <= addr;
        acc_size <= size;
        acc_wdata <= wd;
        acc_rdata_bus <= 32'h1122_3344;
        @(posedge clk) acc_valid <= 1'h0;
        #1;
        check("access error", acc_err, err);
        check("access region", acc_region, reg_code);
        check("access xn", acc_xn, xn);
        check("core periph", acc_core_periph, cp);
        if (!err) begin
            check("byte enable", acc_byte_en, en);
            check("write lanes", acc_wdata_lane, lane);
            check("read data", acc_rdata, rd);
        end
    endtask

    task automatic test_access;
        acc(32'h2000_0003, `CSSR_SIZE_BYTE, 32'h0000_00A5, 4'h8, 32'hA5A5_A5A5, 32'h0000_0011, REG_SRAM, 0, 0, 0);
        acc(32'h0000_0102, `CSSR_SIZE_HALF, 32'h0000_BEEF, 4'hC, 32'hBEEF_BEEF, 32'h0000_1122, REG_CODE, 0, 0, 0);
        acc(32'h6000_0001, `CSSR_SIZE_HALF, 32'h0000_0000, 4'h0, 32'h0000_0000, 32'h0000_0000, REG_EXT_RAM, 0, 0, 1);
        acc(32'h4000_0000, `CSSR_SIZE_WORD, 32'h1234_5678, 4'hF, 32'h1234_5678, 32'h1122_3344, REG_PERIPH, 1, 0, 0);
        acc(32'hA000_0002, `CSSR_SIZE_WORD, 32'h0000_0000, 4'h0, 32'h0000_0000, 32'h0000_0000, REG_EXT_DEVICE, 1, 0, 1);
        acc(32'hE000_E010, `CSSR_SIZE_WORD, 32'hCAFE_0001, 4'hF, 32'hCAFE_0001, 32'h1122_3344, REG_PRIV, 1, 1, 0);
        acc(32'hE000_0001, `CSSR_SIZE_BYTE, 32'h0000_0000, 4'h0, 32'h0000_0000, 32'h0000_0000, REG_PRIV, 1, 0, 1);
        acc(32'hF000_0000, 2'h3, 32'h0000_0000, 4'h0, 32'h0000_0000, 32'h0000_0000, REG_VENDOR, 1, 0, 1);
        $display("test access done");
    endtask

    initial begin
        {rst, reset_vec_load, sreg_rd_en, sreg_wr_en, chg_state_en, chg_state_disable, branch_xchg, exc_entry} = 8'h00;
        {exc_return, return_to_thread, return_proc_stack, instr_issue, in_hard_fault, cfg_exc_req} = 6'h00;
        {multi_start, multi_beat, multi_last, irq_pending, acc_valid} = 5'h00;
        {sreg_sel, acc_size} = 4'h0;
        {reset_vec, sreg_wr_data, branch_target, exc_vector} = 128'h0;
        {stacked_status, acc_addr, acc_wdata, acc_rdata_bus} = 128'h0;
        do_reset(1'h1);
        test_reset_and_status();
        test_mask();
        test_stack_and_fault();
        do_reset(1'h1);
        check("lockup cleared by reset", lockup, 32'h0000_0000);
        test_return_branch();
        test_multi();
        test_access();
        final_report();
    end

    initial begin
        #100000;
        mismatches++;
        final_report();
    end
endmodule
